/* File: src/pgr_regs.svh */
// Constants for the pin and regulator control block.
`ifndef PGR_REGS_SVH
`define PGR_REGS_SVH
`define PGR_NPIN 5
`define PGR_NSW 4
`define PGR_NLDO 4
`define PGR_OUT_LEVEL 3'h0
`define PGR_OUT_FWD 3'h1
`define PGR_OUT_SEQ 3'h2
`define PGR_OUT_CLK 3'h3
`define PGR_OUT_FAULT 3'h4
`define PGR_FAULT_MS 100
`define PGR_ILIM_MS 10
`define PGR_ILIM_SD_MS 200
`define PGR_CLK_KHZ 25000
`define PGR_FAULT_CYC (`PGR_FAULT_MS * `PGR_CLK_KHZ)
`define PGR_ILIM_CYC (`PGR_ILIM_MS * `PGR_CLK_KHZ)
`define PGR_ILIM_SD_CYC (`PGR_ILIM_SD_MS * `PGR_CLK_KHZ)
`endif

/* File: src/pgr_pkg.sv */
// Types for the pin and regulator control block.
package pgr_pkg;
   typedef enum logic [1:0] {
      PGR_FN_ALT = 2'h0,
      PGR_FN_IN = 2'h1,
      PGR_FN_OD = 2'h2,
      PGR_FN_PP = 2'h3
   } pgr_fn_t;
   typedef enum logic [1:0] {
      PGR_SEL_NONE = 2'h0,
      PGR_SEL_PIN1 = 2'h1,
      PGR_SEL_PIN2 = 2'h2,
      PGR_SEL_PIN3 = 2'h3
   } pgr_pinsel_t;
endpackage

/* File: src/pgr_gpio.sv */
// Pin logic, regulator pin control, fault flags and overcurrent handling.
`timescale 1ns/1ps
`include "pgr_regs.svh"
// Contract
// R01: Input event fires on the active edge chosen by per-pin polarity.
// R02: Optional per-pin debounce with one shared software debounce time.
// R03: Wakeup only when enabled; edge or level type selectable per pin.
// R04: Pull bit gives pull-down on inputs, pull-up on open-drain outputs.
// R05: Only pins one to three as inputs control regulators, after polarity.
// R06: One pin may drive many regulators; register writes still apply.
// R07: Pin-assigned regulator functions ignore the power sequencer.
// R08: Pin activation sets regulator enable, deactivation clears it.
// R09: Pin activation sets A/B select, deactivation clears it.
// R10: Pin three feeds sequencer wait step, edge chosen by its polarity.
// R11: Output select zero drives level bit; others route alternative sources.
// R12: Supply fault flag asserts after supply low for over 100 ms.
// R13: Level bit inverts the supply fault flag on an output pin.
// R14: Slow clock buffer gated by sequencer or manual bit; pause in powerdown.
// R15: Alternate inputs on pins zero, two, four: buffer only, optional debounce.
// R16: System enable on pin four: assertion sets bit, interrupt, wakeup.
// R17: Power enable on pin two controls bit; wakeup only if enabled.
// R18: Watchdog kick rising edge resets counter; held level stops counting.
// R19: Debounced pins zero to three may be forwarded to outputs 0, 1, 3.
// R20: Termination enables turn pins zero and one analog, digital disabled.
// R21: Linear regulator sleeps when its active A/B setting has sleep bit.
// R22: Overcurrent over 10 ms raises event; live comparator state visible.
// R23: Function code 0 alternate, 1 input, 2 open-drain, 3 push-pull.
// R24: Pins work only in powerdown and active; otherwise high-Z open-drain.
// R25: Each pin input passes a two-stage synchroniser first.
module pgr_gpio (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] pin_in,
   output logic [4:0] pin_out,
   output logic [4:0] pin_oe,
   output logic [4:0] pin_pull_enable_out,
   input wire pgr_pkg::pgr_fn_t pin_fn [5],
   input wire logic [4:0] pin_polarity_high,
   input wire logic [4:0] pin_debounce_en,
   input wire logic [4:0] pin_level,
   input wire logic [4:0] pin_pull_enable,
   input wire logic [4:0] pin_wake_en,
   input wire logic [4:0] wakeup_type_sel,
   input wire logic [14:0] pin_out_sel,
   input wire logic [9:0] pin_fwd_src,
   input wire logic [15:0] debounce_time,
   input wire logic mode_pins_on,
   input wire logic mode_powerdown,
   input wire logic [4:0] seq_pin_out,
   input wire logic slow_clock_in,
   input wire logic seq_clock_en,
   input wire logic slow_clock_buffer_enable,
   input wire logic slow_clock_pause_enable,
   input wire logic supply_low,
   input wire logic termination_mode_enable,
   input wire logic termination_ref_enable,
   input wire pgr_pkg::pgr_pinsel_t switcher_onoff_pin_sel [4],
   input wire pgr_pkg::pgr_pinsel_t linear_onoff_pin_sel [4],
   input wire pgr_pkg::pgr_pinsel_t switcher_vsel_pin_sel [4],
   input wire pgr_pkg::pgr_pinsel_t linear_vsel_pin_sel [4],
   input wire logic [3:0] sw_en_wr,
   input wire logic [3:0] sw_en_wdata,
   input wire logic [3:0] ln_en_wr,
   input wire logic [3:0] ln_en_wdata,
   input wire logic [3:0] sw_sel_wr,
   input wire logic [3:0] sw_sel_wdata,
   input wire logic [3:0] ln_sel_wr,
   input wire logic [3:0] ln_sel_wdata,
   input wire logic [3:0] seq_sw_en_set,
   input wire logic [3:0] seq_sw_en_clr,
   input wire logic [3:0] seq_ln_en_set,
   input wire logic [3:0] seq_ln_en_clr,
   input wire logic [3:0] seq_sw_sel_wr,
   input wire logic [3:0] seq_ln_sel_wr,
   input wire logic [3:0] seq_sel_val,
   input wire logic [3:0] linear_sleep_on_a,
   input wire logic [3:0] linear_sleep_on_b,
   input wire logic [3:0] ilim_comp,
   input wire logic overcurrent_shutdown_enable,
   output logic [3:0] switcher_enable,
   output logic [3:0] linear_enable_bit,
   output logic [3:0] switcher_ab_select,
   output logic [3:0] linear_ab_select,
   output logic [3:0] linear_sleep,
   output logic [3:0] linear_overcurrent_status,
   output logic linear_overcurrent_event,
   output logic [4:0] input_pin_event,
   output logic [4:0] wakeup_pulse,
   output logic seq_wait_edge,
   output logic system_enable_bit,
   output logic system_down_req,
   output logic power_enable_bit,
   output logic watchdog_clear,
   output logic watchdog_hold_mode,
   output logic supply_fault_flag_n
);
   import pgr_pkg::*;

   logic [4:0] sync1_q, sync2_q, filt_q, act_q, act_d;
   logic [15:0] dcnt_q [5];
   logic [4:0] rise, fall, analog, drv_v;
   logic clk_gate;
   logic [31:0] fault_cnt_q;
   logic [31:0] ilim_cnt_q [4];
   logic [3:0] ilim_hit, ilim_sd;

   // Pins zero and one give way to the termination analog functions.
   assign analog = {3'h0, termination_ref_enable, termination_mode_enable}; // see R20

   // Two flops per pin; only the second stage feeds the filters below.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 5'h0;
         sync2_q <= 5'h0;
      end else begin
         sync1_q <= pin_in; // see R25
         sync2_q <= sync1_q;
      end
   end

   // Debounce: a new level is taken once it has held for the shared time.
   // Each pin counts alone, so a bouncing neighbour cannot delay it.
   for (genvar i = 0; i < `PGR_NPIN; i++) begin : g_deb
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            filt_q[i] <= 1'b0;
            dcnt_q[i] <= 16'h0;
         end else if (!pin_debounce_en[i] || sync2_q[i] == filt_q[i]) begin
            dcnt_q[i] <= 16'h0; // see R02
            filt_q[i] <= sync2_q[i];
         end else if (dcnt_q[i] >= debounce_time) begin
            filt_q[i] <= sync2_q[i]; // see R02, R15
            dcnt_q[i] <= 16'h0;
         end else begin
            dcnt_q[i] <= dcnt_q[i] + 16'h1;
         end
      end
   end

   // Polarity stage; edges are frozen outside the operating modes.
   assign act_d = (filt_q ~^ pin_polarity_high) & ~analog; // see R01
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         act_q <= 5'h0;
      end else if (mode_pins_on) begin
         act_q <= act_d; // see R24
      end
   end
   assign rise = mode_pins_on ? (act_d & ~act_q) : 5'h0;
   assign fall = mode_pins_on ? (~act_d & act_q) : 5'h0;

   // Events and wakeups for inputs and the system enable alternate input.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         input_pin_event <= 5'h0;
         wakeup_pulse <= 5'h0;
      end else begin
         for (int i = 0; i < `PGR_NPIN; i++) begin
            input_pin_event[i] <= rise[i] && (pin_fn[i] == PGR_FN_IN); // see R01, R15
            wakeup_pulse[i] <= pin_wake_en[i] && pin_fn[i] == PGR_FN_IN
               && (wakeup_type_sel[i] ? act_d[i] : rise[i]); // see R03
         end
         if (pin_fn[4] == PGR_FN_ALT && rise[4]) begin
            input_pin_event[4] <= 1'b1; // see R16
            wakeup_pulse[4] <= 1'b1;
         end
         if (pin_fn[2] == PGR_FN_ALT) begin
            wakeup_pulse[2] <= rise[2] && pin_wake_en[2]; // see R17
         end
      end
   end

   // Alternate functions: system enable, power enable, watchdog kick.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         system_enable_bit <= 1'b0;
         system_down_req <= 1'b0;
         power_enable_bit <= 1'b0;
         watchdog_clear <= 1'b0;
         watchdog_hold_mode <= 1'b0;
         seq_wait_edge <= 1'b0;
      end else begin
         system_down_req <= 1'b0;
         if (pin_fn[4] == PGR_FN_ALT && rise[4]) begin
            system_enable_bit <= 1'b1; // see R16
         end else if (pin_fn[4] == PGR_FN_ALT && fall[4]) begin
            system_enable_bit <= 1'b0;
            system_down_req <= 1'b1;
         end
         if (pin_fn[2] == PGR_FN_ALT && (rise[2] || fall[2])) begin
            power_enable_bit <= rise[2]; // see R17
         end
         watchdog_clear <= pin_fn[0] == PGR_FN_ALT && rise[0]; // see R18
         watchdog_hold_mode <= pin_fn[0] == PGR_FN_ALT && act_d[0] && mode_pins_on;
         seq_wait_edge <= pin_fn[3] == PGR_FN_IN && rise[3]; // see R10
      end
   end

   // Regulator control bits: pin edges first, then register writes, and
   // the sequencer only for functions no pin has claimed.
   function automatic logic reg_next(input logic cur, input pgr_pinsel_t s,
         input logic [4:0] r, input logic [4:0] f, input pgr_fn_t fn1,
         input pgr_fn_t fn2, input pgr_fn_t fn3, input logic wr,
         input logic wd, input logic sset, input logic sclr);
      logic v;
      logic ok;
      v = cur;
      ok = (s == PGR_SEL_PIN1 && fn1 == PGR_FN_IN)
         || (s == PGR_SEL_PIN2 && fn2 == PGR_FN_IN)
         || (s == PGR_SEL_PIN3 && fn3 == PGR_FN_IN); // see R05
      if (s == PGR_SEL_NONE) begin
         if (sset) v = 1'b1; // see R07
         if (sclr) v = 1'b0;
      end
      if (ok && r[s]) v = 1'b1; // see R08, R09
      if (ok && f[s]) v = 1'b0;
      if (wr) v = wd; // see R06
      return v;
   endfunction

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         switcher_enable <= 4'h0;
         linear_enable_bit <= 4'h0;
         switcher_ab_select <= 4'h0;
         linear_ab_select <= 4'h0;
      end else begin
         for (int k = 0; k < `PGR_NSW; k++) begin
            switcher_enable[k] <= reg_next(switcher_enable[k],
               switcher_onoff_pin_sel[k], rise, fall, pin_fn[1], pin_fn[2],
               pin_fn[3], sw_en_wr[k], sw_en_wdata[k], seq_sw_en_set[k],
               seq_sw_en_clr[k]);
            linear_enable_bit[k] <= reg_next(linear_enable_bit[k],
               linear_onoff_pin_sel[k], rise, fall, pin_fn[1], pin_fn[2],
               pin_fn[3], ln_en_wr[k], ln_en_wdata[k], seq_ln_en_set[k],
               seq_ln_en_clr[k]) && !ilim_sd[k];
            switcher_ab_select[k] <= reg_next(switcher_ab_select[k],
               switcher_vsel_pin_sel[k], rise, fall, pin_fn[1], pin_fn[2],
               pin_fn[3], sw_sel_wr[k], sw_sel_wdata[k],
               seq_sw_sel_wr[k] && seq_sel_val[k],
               seq_sw_sel_wr[k] && !seq_sel_val[k]);
            linear_ab_select[k] <= reg_next(linear_ab_select[k],
               linear_vsel_pin_sel[k], rise, fall, pin_fn[1], pin_fn[2],
               pin_fn[3], ln_sel_wr[k], ln_sel_wdata[k],
               seq_ln_sel_wr[k] && seq_sel_val[k],
               seq_ln_sel_wr[k] && !seq_sel_val[k]);
         end
      end
   end

   // Overcurrent timers; the event fires once when a count reaches 10 ms.
   for (genvar k = 0; k < `PGR_NLDO; k++) begin : g_ilim
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            ilim_cnt_q[k] <= 32'h0;
         end else if (!ilim_comp[k]) begin
            ilim_cnt_q[k] <= 32'h0;
         end else if (ilim_cnt_q[k] < 32'(`PGR_ILIM_SD_CYC)) begin
            ilim_cnt_q[k] <= ilim_cnt_q[k] + 32'h1;
         end
      end
      assign ilim_hit[k] = ilim_cnt_q[k] == 32'(`PGR_ILIM_CYC); // see R22
      assign ilim_sd[k] = overcurrent_shutdown_enable
         && ilim_cnt_q[k] == 32'(`PGR_ILIM_SD_CYC);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         linear_overcurrent_event <= 1'b0;
         linear_overcurrent_status <= 4'h0;
         linear_sleep <= 4'h0;
      end else begin
         linear_overcurrent_event <= |ilim_hit; // see R22
         linear_overcurrent_status <= ilim_comp;
         linear_sleep <= (linear_ab_select & linear_sleep_on_b)
            | (~linear_ab_select & linear_sleep_on_a); // see R21
      end
   end

   // Supply fault: low flag once the supply has been low past 100 ms.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_cnt_q <= 32'h0;
         supply_fault_flag_n <= 1'b1;
      end else if (!supply_low) begin
         fault_cnt_q <= 32'h0;
         supply_fault_flag_n <= 1'b1;
      end else if (fault_cnt_q < 32'(`PGR_FAULT_CYC)) begin
         fault_cnt_q <= fault_cnt_q + 32'h1;
      end else begin
         supply_fault_flag_n <= 1'b0; // see R12
      end
   end

   // The clock buffer gate; a glitch at switch time is accepted.
   assign clk_gate = (seq_clock_en || slow_clock_buffer_enable)
      && !(slow_clock_pause_enable && mode_powerdown); // see R14

   // Value each pin would show before the driver type is applied.
   // A set level bit inverts the supply fault flag on its way out.
   always_comb begin
      for (int i = 0; i < `PGR_NPIN; i++) begin
         case (pin_out_sel[3*i +: 3])
            `PGR_OUT_LEVEL: drv_v[i] = pin_level[i]; // see R11
            `PGR_OUT_FWD: drv_v[i] = (i != 2 && i != 4)
               ? filt_q[pin_fwd_src[2*i +: 2]] : pin_level[i]; // see R19
            `PGR_OUT_SEQ: drv_v[i] = seq_pin_out[i];
            `PGR_OUT_CLK: drv_v[i] = slow_clock_in && clk_gate; // see R14
            `PGR_OUT_FAULT: drv_v[i] = supply_fault_flag_n
               ^ pin_level[i]; // see R13
            default: drv_v[i] = pin_level[i];
         endcase
      end
   end

   // Output drivers. Outside operating modes every pin is a released
   // open-drain, but its programmed level is kept in the inputs.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out <= 5'h0;
         pin_oe <= 5'h0;
         pin_pull_enable_out <= 5'h0;
      end else begin
         for (int i = 0; i < `PGR_NPIN; i++) begin
            pin_out[i] <= (pin_fn[i] == PGR_FN_PP) ? drv_v[i] : 1'b0; // see R23
            pin_oe[i] <= mode_pins_on && !analog[i]
               && ((pin_fn[i] == PGR_FN_PP)
               || (pin_fn[i] == PGR_FN_OD && !drv_v[i])); // see R24, R20
            pin_pull_enable_out[i] <= pin_pull_enable[i] && !analog[i]
               && (pin_fn[i] == PGR_FN_IN || pin_fn[i] == PGR_FN_OD); // see R04
         end
      end
   end
endmodule

/* File: testbench/pgr_gpio_props.sv */
// Assertion checker for the pin and regulator control block.
`timescale 1ns/1ps
module pgr_gpio_props import pgr_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire pgr_pkg::pgr_fn_t pin_fn [5],
   input wire logic [4:0] pin_level,
   input wire logic [14:0] pin_out_sel,
   input wire logic mode_pins_on,
   input wire logic supply_low,
   input wire logic [3:0] sw_en_wr,
   input wire logic [3:0] sw_en_wdata,
   input wire logic [3:0] linear_sleep_on_a,
   input wire logic [3:0] linear_sleep_on_b,
   input wire logic [3:0] ilim_comp,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   input wire logic [3:0] linear_ab_select,
   input wire logic [3:0] linear_sleep,
   input wire logic [3:0] linear_overcurrent_status,
   input wire logic [4:0] input_pin_event,
   input wire logic [3:0] switcher_enable,
   input wire logic supply_fault_flag_n
);
   // All checks share the one clock and its asynchronous reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_pins_off_hiz: assert property (!mode_pins_on [*2] |-> pin_oe == 5'h0)
      else $error("pin driven while pins are off");
   a_event_quiet: assert property (!mode_pins_on [*6] |-> input_pin_event == 5'h0)
      else $error("input event while pins are off");
   a_event_pulse: assert property (input_pin_event[1] |=> !input_pin_event[1])
      else $error("input event longer than one cycle");
   a_fault_clear: assert property (!supply_low |=> supply_fault_flag_n)
      else $error("fault flag without low supply");
   a_wr_priority: assert property (sw_en_wr[0] |=>
      switcher_enable[0] == $past(sw_en_wdata[0]))
      else $error("register write to enable lost");
   // Settled sleep links and settled comparator give fixed outputs.
   a_sleep_link: assert property (($stable(linear_ab_select) &&
      $stable(linear_sleep_on_a) && $stable(linear_sleep_on_b)) [*3] |->
      linear_sleep == ((linear_ab_select & linear_sleep_on_b) |
      (~linear_ab_select & linear_sleep_on_a)))
      else $error("sleep does not follow active setting");
   a_ilim_live: assert property ($stable(ilim_comp) [*3] |->
      linear_overcurrent_status == ilim_comp)
      else $error("overcurrent status not live");
   a_pp_level: assert property ((pin_fn[3] == PGR_FN_PP && mode_pins_on &&
      pin_out_sel[11:9] == 3'h0 && $stable(pin_level[3])) [*3] |->
      pin_oe[3] && pin_out[3] == pin_level[3])
      else $error("push-pull pin ignores level bit");
   a_od_drive: assert property ((pin_fn[3] == PGR_FN_OD && mode_pins_on &&
      pin_out_sel[11:9] == 3'h0 && $stable(pin_level[3])) [*3] |->
      pin_oe[3] == !pin_level[3])
      else $error("open-drain pin drive wrong");
endmodule
bind pgr_gpio pgr_gpio_props i_pgr_gpio_props (.clk, .rst_b, .pin_fn,
   .pin_level, .pin_out_sel, .mode_pins_on, .supply_low, .sw_en_wr,
   .sw_en_wdata, .linear_sleep_on_a, .linear_sleep_on_b, .ilim_comp,
   .pin_out, .pin_oe, .linear_ab_select, .linear_sleep,
   .linear_overcurrent_status, .input_pin_event, .switcher_enable,
   .supply_fault_flag_n);

/* File: testbench/pgr_pin_model.sv */
// Far-side pin model: outside drivers, pull resistors and floating wires.
`timescale 1ns/1ps
module pgr_pin_model import pgr_pkg::*; (
   input wire logic clk,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   input wire logic [4:0] pin_pull_enable_out,
   input wire pgr_pkg::pgr_fn_t pin_fn [5],
   input wire logic [4:0] ext_en,
   input wire logic [4:0] ext_val,
   output logic [4:0] pin_in
);
   // Starts known, so that a floating pin never feeds unknowns inward.
   logic [4:0] last_q = 5'h0;
   // A floating wire shows the inverse of its last level, never a held one.
   always @(posedge clk) begin
      last_q <= pin_in;
   end
   // Device drive wins, then the outside driver, then the pulls.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pin_pull_enable_out[i]) pin_in[i] = (pin_fn[i] == PGR_FN_OD);
         else pin_in[i] = ~last_q[i];
      end
   end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the pin and regulator control block.
`timescale 1ns/1ps
module testbench;
   import pgr_pkg::*;
   logic clk, rst_b, mode_pins_on, mode_powerdown, slow_clock_in;
   logic seq_clock_en, slow_clock_buffer_enable, slow_clock_pause_enable;
   logic supply_low, termination_mode_enable, termination_ref_enable;
   logic overcurrent_shutdown_enable, linear_overcurrent_event;
   logic [4:0] pin_in, pin_out, pin_oe, pin_pull_enable_out;
   logic [4:0] pin_polarity_high, pin_debounce_en, pin_level;
   logic [4:0] pin_pull_enable, pin_wake_en, wakeup_type_sel, seq_pin_out;
   logic [4:0] input_pin_event, wakeup_pulse, ext_en, ext_val;
   logic [14:0] pin_out_sel;
   logic [9:0] pin_fwd_src;
   logic [15:0] debounce_time;
   pgr_fn_t pin_fn [5];
   pgr_pinsel_t switcher_onoff_pin_sel [4], linear_onoff_pin_sel [4];
   pgr_pinsel_t switcher_vsel_pin_sel [4], linear_vsel_pin_sel [4];
   logic [3:0] sw_en_wr, sw_en_wdata, ln_en_wr, ln_en_wdata, sw_sel_wr;
   logic [3:0] sw_sel_wdata, ln_sel_wr, ln_sel_wdata, seq_sw_en_set;
   logic [3:0] seq_sw_en_clr, seq_ln_en_set, seq_ln_en_clr, seq_sw_sel_wr;
   logic [3:0] seq_ln_sel_wr, seq_sel_val, linear_sleep_on_a, ilim_comp;
   logic [3:0] linear_sleep_on_b, switcher_enable, linear_enable_bit;
   logic [3:0] switcher_ab_select, linear_ab_select, linear_sleep;
   logic [3:0] linear_overcurrent_status;
   logic seq_wait_edge, system_enable_bit, system_down_req, power_enable_bit;
   logic watchdog_clear, watchdog_hold_mode, supply_fault_flag_n;
   int bad_count = 0, compares = 0, cyc = 0, hits = 0, h0;

   pgr_gpio i_pgr_gpio (.*);
   pgr_pin_model i_pgr_pin_model (.clk, .pin_out, .pin_oe,
      .pin_pull_enable_out, .pin_fn, .ext_en, .ext_val, .pin_in);

   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Counts pin one events; a hang is cut short well after the last test.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (input_pin_event[1] === 1'b1) hits <= hits + 1;
      if (cyc == 2000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic s(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Every input gets a value at time zero; pins 0, 1, 2, 4 are driven low.
   initial begin
      {rst_b, mode_powerdown, slow_clock_in, seq_clock_en, supply_low} = '0;
      {slow_clock_buffer_enable, slow_clock_pause_enable, ilim_comp} = '0;
      {termination_mode_enable, termination_ref_enable, seq_pin_out} = '0;
      {overcurrent_shutdown_enable, pin_debounce_en, pin_level} = '0;
      {pin_pull_enable, pin_wake_en, wakeup_type_sel, pin_out_sel} = '0;
      {pin_fwd_src, debounce_time, sw_en_wr, sw_en_wdata, ln_en_wr} = '0;
      {ln_en_wdata, sw_sel_wr, sw_sel_wdata, ln_sel_wr, ln_sel_wdata} = '0;
      {seq_sw_en_set, seq_sw_en_clr, seq_ln_en_set, seq_ln_en_clr} = '0;
      {seq_sw_sel_wr, seq_ln_sel_wr, seq_sel_val, ext_val} = '0;
      {linear_sleep_on_a, linear_sleep_on_b} = '0;
      mode_pins_on = 1'b1;
      pin_polarity_high = 5'h1f;
      ext_en = 5'h17;
      pin_fn = '{PGR_FN_IN, PGR_FN_IN, PGR_FN_IN, PGR_FN_IN, PGR_FN_ALT};
      switcher_onoff_pin_sel = '{default: PGR_SEL_NONE};
      linear_onoff_pin_sel = '{default: PGR_SEL_NONE};
      switcher_vsel_pin_sel = '{default: PGR_SEL_NONE};
      linear_vsel_pin_sel = '{default: PGR_SEL_NONE};
      s(3);
      rst_b <= 1'b1;
      // Pin one steers three regulator functions; the sequencer is locked out.
      s(1);
      switcher_onoff_pin_sel[0] <= PGR_SEL_PIN1;
      linear_onoff_pin_sel[2] <= PGR_SEL_PIN1;
      switcher_vsel_pin_sel[1] <= PGR_SEL_PIN1;
      s(6);
      seq_sw_en_set <= 4'h1;
      s(1);
      seq_sw_en_set <= 4'h0;
      s(3);
      #1 check(switcher_enable, 4'h0);
      h0 = hits;
      s(1);
      ext_val[1] <= 1'b1;
      s(8);
      #1 check(8'(hits - h0), 8'h1);
      check({switcher_enable[0], linear_enable_bit[2]}, 8'h3);
      check(switcher_ab_select, 4'h2);
      s(1);
      sw_en_wr <= 4'h1;
      s(1);
      sw_en_wr <= 4'h0;
      s(2);
      #1 check(switcher_enable, 4'h0);
      s(1);
      ext_val[1] <= 1'b0;
      s(8);
      #1 check(8'(hits - h0), 8'h1);
      check({linear_enable_bit, switcher_ab_select}, 8'h0);
      // Active low: rising is the passive edge, falling the active one.
      s(1);
      pin_polarity_high[1] <= 1'b0;
      s(6);
      ext_val[1] <= 1'b1;
      s(8);
      #1 check(switcher_enable, 4'h0);
      h0 = hits;
      s(1);
      ext_val[1] <= 1'b0;
      s(8);
      #1 check(8'(hits - h0), 8'h1);
      check(switcher_enable, 4'h1);
      $display("Test 1 done");
      // Pin three output: every function code, then level and fault sources.
      for (int f = 0; f < 4; f++) begin
         s(1);
         pin_fn[3] <= pgr_fn_t'(f);
         s(4);
         #1 check(pin_oe[3], f[1]);
      end
      s(1);
      pin_level[3] <= 1'b1;
      s(4);
      #1 check({pin_oe[3], pin_out[3]}, 8'h3);
      s(1);
      pin_out_sel[11:9] <= 3'h4;
      s(4);
      #1 check({pin_oe[3], pin_out[3]}, 8'h2);
      s(1);
      mode_pins_on <= 1'b0;
      s(7);
      #1 check(pin_oe, 5'h0);
      s(1);
      mode_pins_on <= 1'b1;
      pin_out_sel[11:9] <= 3'h0;
      pin_fn[3] <= PGR_FN_OD;
      pin_pull_enable[3] <= 1'b1;
      s(4);
      #1 check({pin_pull_enable_out[3], pin_in[3]}, 8'h3);
      $display("Test 2 done");
      // Sleep follows the active setting; status and system enable follow.
      s(1);
      linear_sleep_on_a <= 4'h1;
      linear_sleep_on_b <= 4'h2;
      ln_sel_wr <= 4'h3;
      ln_sel_wdata <= 4'h2;
      ilim_comp <= 4'h5;
      ext_val[4] <= 1'b1;
      s(1);
      ln_sel_wr <= 4'h0;
      s(6);
      #1 check(linear_sleep, 4'h3);
      check(linear_overcurrent_status, 4'h5);
      check(system_enable_bit, 1'b1);
      s(1);
      ln_sel_wr <= 4'h3;
      ln_sel_wdata <= 4'h1;
      s(1);
      ln_sel_wr <= 4'h0;
      s(3);
      #1 check(linear_sleep, 4'h0);
      $display("Test 3 done");
      // Alternate inputs, wakeups, forwarding, debounce and the wait step.
      s(1);
      pin_fn[0] <= PGR_FN_ALT;
      pin_fn[2] <= PGR_FN_ALT;
      pin_wake_en[2] <= 1'b1;
      ext_val[4] <= 1'b0;
      s(4);
      #1 check({system_down_req, system_enable_bit, input_pin_event[4]},
         8'h4);
      s(1);
      ext_val[0] <= 1'b1;
      ext_val[2] <= 1'b1;
      s(4);
      #1 check({watchdog_clear, watchdog_hold_mode, power_enable_bit,
         wakeup_pulse[2], input_pin_event[2]}, 8'h1e);
      s(1);
      #1 check({watchdog_clear, watchdog_hold_mode, wakeup_pulse[2]},
         8'h2);
      s(1);
      ext_val[2] <= 1'b0;
      pin_wake_en[1] <= 1'b1;
      wakeup_type_sel[1] <= 1'b1;
      pin_out_sel[11:9] <= 3'h1;
      pin_fwd_src[7:6] <= 2'h2;
      s(4);
      #1 check({power_enable_bit, wakeup_pulse[1], pin_oe[3]},
         8'h3);
      s(1);
      pin_debounce_en[1] <= 1'b1;
      debounce_time <= 16'h8;
      ext_val[1] <= 1'b1;
      s(6);
      #1 check(wakeup_pulse[1], 1'b1);
      s(7);
      #1 check(wakeup_pulse[1], 1'b0);
      s(1);
      pin_fn[3] <= PGR_FN_IN;
      ext_en[3] <= 1'b1;
      s(6);
      ext_val[3] <= 1'b1;
      s(4);
      #1 check({seq_wait_edge, input_pin_event[3]}, 8'h3);
      check({linear_overcurrent_event, supply_fault_flag_n}, 8'h1);
      $display("Test 4 done");
      end_sim();
   end
endmodule
